// ==== hw/upfp_ctrl.sv ====
/*
  Controller end: turns byte requests into strobe sequences on the port and
  can drive the remote wakeup pulse.
  Assumes the bridge end meets the pin behaviour described with it.
*/
`default_nettype none
module upfp_ctrl #(
  parameter int WAKE_CYC = upfp_pkg::WAKE_HOLD_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // pins
  upfp_if.ctrl PIN,
  // user requests
  input wire logic RD_REQ,
  input wire logic WR_REQ,
  input wire logic [7:0] WR_DATA,
  input wire logic WAKE_REQ,
  output logic BUSY,
  output logic RD_VALID,
  output logic [7:0] RD_DATA,
  output logic WR_DONE,
  output logic RESET_OUT_N,
  output logic TEST_OUT
);
  upfp_pkg::upfp_ctl_state_t state_reg;
  logic [upfp_pkg::WAKE_CNT_W-1:0] hold_cnt_reg;
  logic rd_n_reg, wr_reg, bus_oe_reg, wake_oe_reg, busy_reg, rd_valid_reg, wr_done_reg;
  logic [7:0] bus_reg, rd_data_reg;

  // requests wait in their state until the status pin allows the transfer,
  // so a byte is never lost when the bridge is still busy
  always_ff @(posedge CLK)
    if (!RST_N)
    begin
      state_reg <= upfp_pkg::UPFP_C_IDLE;
      rd_n_reg <= upfp_pkg::LVL_HI;
      wr_reg <= upfp_pkg::LVL_LO;
      bus_oe_reg <= upfp_pkg::LVL_LO;
      wake_oe_reg <= upfp_pkg::LVL_LO;
      busy_reg <= upfp_pkg::LVL_LO;
      rd_valid_reg <= upfp_pkg::LVL_LO;
      wr_done_reg <= upfp_pkg::LVL_LO;
      bus_reg <= upfp_pkg::BYTE_ZERO;
      rd_data_reg <= upfp_pkg::BYTE_ZERO;
      hold_cnt_reg <= '0;
    end
    else
    begin
      rd_valid_reg <= upfp_pkg::LVL_LO;
      wr_done_reg <= upfp_pkg::LVL_LO;
      case (state_reg)
        upfp_pkg::UPFP_C_IDLE:
          if (RD_REQ)
          begin
            state_reg <= upfp_pkg::UPFP_C_RD_LOW;
            busy_reg <= upfp_pkg::LVL_HI;
          end
          else if (WR_REQ)
          begin
            bus_reg <= WR_DATA;
            state_reg <= upfp_pkg::UPFP_C_WR_HIGH;
            busy_reg <= upfp_pkg::LVL_HI;
          end
          else if (WAKE_REQ)
          begin
            wake_oe_reg <= upfp_pkg::LVL_HI; // R10
            hold_cnt_reg <= '0;
            state_reg <= upfp_pkg::UPFP_C_WAKE;
            busy_reg <= upfp_pkg::LVL_HI;
          end
        upfp_pkg::UPFP_C_RD_LOW:
          if (!rd_n_reg)
            state_reg <= upfp_pkg::UPFP_C_RD_HIGH;
          else if (!PIN.rx_avail_n)
            rd_n_reg <= upfp_pkg::LVL_LO; // R7 R8
        upfp_pkg::UPFP_C_RD_HIGH:
        begin
          // bridge has driven the byte for a full cycle by now
          rd_data_reg <= PIN.fifo_data_bus; // R8
          rd_valid_reg <= upfp_pkg::LVL_HI;
          rd_n_reg <= upfp_pkg::LVL_HI; // R8
          busy_reg <= upfp_pkg::LVL_LO;
          state_reg <= upfp_pkg::UPFP_C_IDLE;
        end
        upfp_pkg::UPFP_C_WR_HIGH:
          if (!PIN.tx_space_n)
          begin
            wr_reg <= upfp_pkg::LVL_HI; // R4 R5
            bus_oe_reg <= upfp_pkg::LVL_HI;
            state_reg <= upfp_pkg::UPFP_C_WR_LOW;
          end
        upfp_pkg::UPFP_C_WR_LOW:
          if (wr_reg)
            wr_reg <= upfp_pkg::LVL_LO; // R5
          else
          begin
            // data held through the falling strobe edge the bridge samples
            bus_oe_reg <= upfp_pkg::LVL_LO;
            wr_done_reg <= upfp_pkg::LVL_HI;
            busy_reg <= upfp_pkg::LVL_LO;
            state_reg <= upfp_pkg::UPFP_C_IDLE;
          end
        upfp_pkg::UPFP_C_WAKE:
          if (hold_cnt_reg == upfp_pkg::WAKE_CNT_W'(WAKE_CYC + 1))
          begin
            wake_oe_reg <= upfp_pkg::LVL_LO;
            busy_reg <= upfp_pkg::LVL_LO;
            state_reg <= upfp_pkg::UPFP_C_IDLE;
          end
          else
            hold_cnt_reg <= hold_cnt_reg + 1'b1; // R10
        default:
          state_reg <= upfp_pkg::UPFP_C_IDLE;
      endcase
    end

  always_ff @(posedge CLK)
    if (!RST_N)
    begin
      RESET_OUT_N <= upfp_pkg::LVL_HI;
      TEST_OUT <= upfp_pkg::LVL_LO;
    end
    else
    begin
      RESET_OUT_N <= upfp_pkg::LVL_HI; // R14
      TEST_OUT <= upfp_pkg::LVL_LO; // R15
    end

  assign PIN.rd_n = rd_n_reg;
  assign PIN.wr = wr_reg;
  assign PIN.bus_ctl = bus_reg;
  assign PIN.bus_ctl_oe = bus_oe_reg;
  assign PIN.rx_avail_ext = upfp_pkg::LVL_LO;
  assign PIN.rx_avail_ext_oe = wake_oe_reg;
  assign BUSY = busy_reg;
  assign RD_VALID = rd_valid_reg;
  assign RD_DATA = rd_data_reg;
  assign WR_DONE = wr_done_reg;
endmodule : upfp_ctrl
`default_nettype wire

// ==== hw/upfp_pkg.sv ====
/*
  Package for the parallel FIFO port: widths, pin levels and timing counts
  shared by the bridge end and the controller end, and the controller state encodings.
  Assumes a single 200 MHz clock on both ends.
*/
`default_nettype none
package upfp_pkg;
  localparam int DATA_W = 8;
  localparam int CLK_MHZ = 200;
  // remote wakeup hold time
  localparam int WAKE_HOLD_MS = 20;
  localparam int WAKE_HOLD_CYC = WAKE_HOLD_MS * CLK_MHZ * 1000;
  localparam int WAKE_CNT_W = 24;
  localparam logic LVL_HI = 1'b1;
  localparam logic LVL_LO = 1'b0;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  typedef enum logic [2:0] {
    UPFP_C_IDLE = 3'b000,
    UPFP_C_RD_LOW = 3'b001,
    UPFP_C_RD_HIGH = 3'b010,
    UPFP_C_WR_HIGH = 3'b011,
    UPFP_C_WR_LOW = 3'b100,
    UPFP_C_WAKE = 3'b101
  } upfp_ctl_state_t;
endpackage : upfp_pkg
`default_nettype wire

// ==== hw/upfp_if.sv ====
/*
  Pin-level link between the bridge end and the controller end.
  Bidirectional pins appear as in/out/enable triples; the wire level is
  resolved here, with the weak pull-up and suspend pull-down of the bridge.
*/
`default_nettype none
interface upfp_if;
  logic rd_n;
  logic wr;
  logic tx_space_n;
  logic tx_space_oe;
  logic rx_avail_out;
  logic rx_avail_oe;
  logic rx_avail_ext;
  logic rx_avail_ext_oe;
  logic rx_avail_n;
  logic power_enable_n;
  logic [7:0] bus_dev;
  logic bus_dev_oe;
  logic [7:0] bus_ctl;
  logic bus_ctl_oe;
  logic [7:0] fifo_data_bus;
  logic pull_low;
  // the status pin idles high: pulling it low in suspend would look like a wakeup
  assign rx_avail_n = rx_avail_oe ? rx_avail_out :
                      rx_avail_ext_oe ? rx_avail_ext : upfp_pkg::LVL_HI;
  assign fifo_data_bus = bus_dev_oe ? bus_dev : bus_ctl_oe ? bus_ctl :
                         {8{~pull_low}};
  modport device (
    input rd_n, wr, rx_avail_n, fifo_data_bus,
    output tx_space_n, tx_space_oe, rx_avail_out, rx_avail_oe,
    output power_enable_n, bus_dev, bus_dev_oe, pull_low
  );
  modport ctrl (
    input tx_space_n, rx_avail_n, power_enable_n, fifo_data_bus,
    output rd_n, wr, rx_avail_ext, rx_avail_ext_oe, bus_ctl, bus_ctl_oe
  );
endinterface : upfp_if
`default_nettype wire

// ==== hw/upfp_device.sv ====
/*
  Bridge end of the parallel FIFO port: one receive byte slot fed from the
  USB side, one transmit byte slot drained by it, status pins, power enable
  and remote wakeup detection.
  Assumes strobes synchronous to CLK and the interface resolving pin levels.
*/
// Contract
// R1 - drive receive byte while read strobe low
// R2 - read strobe fall fetches next available byte
// R3 - write strobe fall captures bus byte
// R4 - controller never writes while tx space high
// R5 - controller writes by strobing write high then low
// R6 - status pins tri-state during reset
// R7 - controller never reads while rx avail high
// R8 - rx avail low when data; read strobes low-high
// R9 - suspend with wakeup: rx avail pin input
// R10 - 20ms low hold requests USB resume
// R11 - power enable low configured, high suspended
// R12 - use suspend pull-down when switching power
// R13 - optional weak pull-low of inputs in suspend
// R14 - external active-low reset input
// R15 - test input held low for normal operation
// R16 - one shared eight-bit bus, bits 0..7
// R17 - internal clock default; oscillator optional
// R18 - release bus whenever read strobe high
// R19 - status deasserted after transfer until ready
`default_nettype none
module upfp_device #(
  parameter int WAKE_CYC = upfp_pkg::WAKE_HOLD_CYC
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // pins
  upfp_if.device PIN,
  input wire logic TEST,
  input wire logic OSC_IN_PIN,
  output logic OSC_OUT_PIN,
  // USB engine side
  input wire logic USB_CONFIGURED,
  input wire logic USB_SUSPEND,
  input wire logic CFG_REMOTE_WAKE,
  input wire logic CFG_SUSPEND_PULL,
  input wire logic RX_VALID,
  input wire logic [7:0] RX_DATA,
  output logic RX_READY,
  output logic TX_VALID,
  output logic [7:0] TX_DATA,
  input wire logic TX_READY,
  output logic RESUME_REQ
);
  logic rd_n_reg, wr_reg, rx_full_reg, tx_full_reg, pwr_n_reg, dev_oe_reg;
  logic [7:0] rx_byte_reg, out_byte_reg;
  logic [upfp_pkg::WAKE_CNT_W-1:0] wake_cnt_reg;
  logic rd_fall, wr_fall, suspended, wake_input;

  assign rd_fall = rd_n_reg & ~PIN.rd_n;
  assign wr_fall = wr_reg & ~PIN.wr;
  assign suspended = pwr_n_reg;
  assign wake_input = suspended & CFG_REMOTE_WAKE; // R9
  // internal generator is used; the oscillator cell just inverts its input
  assign OSC_OUT_PIN = ~OSC_IN_PIN; // R17
  assign RX_READY = ~rx_full_reg & rd_n_reg;
  assign TX_VALID = tx_full_reg;

  always_ff @(posedge CLK)
    if (!RST_N)
    begin
      rd_n_reg <= upfp_pkg::LVL_HI;
      wr_reg <= upfp_pkg::LVL_LO;
    end
    else
    begin
      rd_n_reg <= PIN.rd_n;
      wr_reg <= PIN.wr;
    end

  // receive slot: refilled only after the strobe has returned high
  always_ff @(posedge CLK)
    if (!RST_N || TEST)
    begin
      rx_full_reg <= upfp_pkg::LVL_LO;
      rx_byte_reg <= upfp_pkg::BYTE_ZERO;
    end
    else if (rd_fall && rx_full_reg)
      rx_full_reg <= upfp_pkg::LVL_LO; // R2 R19
    else if (RX_VALID && RX_READY)
    begin
      rx_full_reg <= upfp_pkg::LVL_HI;
      rx_byte_reg <= RX_DATA;
    end

  always_ff @(posedge CLK)
    if (!RST_N)
      out_byte_reg <= upfp_pkg::BYTE_ZERO;
    else if (rd_fall && rx_full_reg)
      out_byte_reg <= rx_byte_reg; // R2

  // bus driven only while the strobe is low, released on its rise
  always_ff @(posedge CLK)
    if (!RST_N)
      dev_oe_reg <= upfp_pkg::LVL_LO;
    else
      dev_oe_reg <= ~PIN.rd_n & (dev_oe_reg | (rd_fall & rx_full_reg)); // R1 R18
  assign PIN.bus_dev = out_byte_reg; // R16
  assign PIN.bus_dev_oe = dev_oe_reg & ~PIN.rd_n; // R18

  // transmit slot
  always_ff @(posedge CLK)
    if (!RST_N || TEST)
    begin
      tx_full_reg <= upfp_pkg::LVL_LO;
      TX_DATA <= upfp_pkg::BYTE_ZERO;
    end
    else if (wr_fall && !tx_full_reg)
    begin
      tx_full_reg <= upfp_pkg::LVL_HI; // R3 R19
      TX_DATA <= PIN.fifo_data_bus;
    end
    else if (TX_READY)
      tx_full_reg <= upfp_pkg::LVL_LO;

  always_ff @(posedge CLK)
    if (!RST_N)
      pwr_n_reg <= upfp_pkg::LVL_HI;
    else if (USB_SUSPEND)
      pwr_n_reg <= upfp_pkg::LVL_HI; // R11
    else if (USB_CONFIGURED)
      pwr_n_reg <= upfp_pkg::LVL_LO; // R11
  assign PIN.power_enable_n = pwr_n_reg;
  assign PIN.pull_low = suspended & CFG_SUSPEND_PULL; // R13

  // wakeup: count cycles the pin stays low, fire once at the hold time
  always_ff @(posedge CLK)
    if (!RST_N || !wake_input || PIN.rx_avail_n)
    begin
      wake_cnt_reg <= '0;
      RESUME_REQ <= upfp_pkg::LVL_LO;
    end
    else
    begin
      RESUME_REQ <= (wake_cnt_reg == upfp_pkg::WAKE_CNT_W'(WAKE_CYC - 1)); // R10
      if (wake_cnt_reg != upfp_pkg::WAKE_CNT_W'(WAKE_CYC))
        wake_cnt_reg <= wake_cnt_reg + 1'b1;
    end

  // the reset input is synchronous; the status pins float while it is held
  assign PIN.tx_space_n = tx_full_reg | suspended; // R19
  assign PIN.tx_space_oe = RST_N; // R6 R14
  assign PIN.rx_avail_out = ~rx_full_reg | dev_oe_reg; // R8 R19
  assign PIN.rx_avail_oe = RST_N & ~wake_input; // R6 R9
endmodule : upfp_device
`default_nettype wire

// ==== tb/upfp_chk.sv ====
/* upfp_chk: assertions on the pin link between the two ends
   assumes one clock and a synchronous active-low reset */
`default_nettype none
module upfp_chk (
  // clock and reset
  input wire logic CLK,
  input wire logic RST_N,
  // pins
  input wire logic rd_n,
  input wire logic wr,
  input wire logic tx_space_n,
  input wire logic tx_space_oe,
  input wire logic rx_avail_oe,
  input wire logic rx_avail_ext_oe,
  input wire logic rx_avail_n,
  input wire logic power_enable_n,
  input wire logic bus_dev_oe,
  input wire logic pull_low
);
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  a_bus_release: assert property (rd_n |-> !bus_dev_oe)
    else $error("bus not released");
  a_read_drive: assert property ((!rd_n) [*2] |-> bus_dev_oe)
    else $error("read byte not driven");
  // the status enables follow RST_N directly and already float in the first reset cycle
  a_reset_float: assert property (disable iff (1'b0)
    (!RST_N) [*2] |-> !tx_space_oe && !rx_avail_oe)
    else $error("status driven in reset");
  a_write_space: assert property ($rose(wr) |-> !$past(tx_space_n))
    else $error("write without space");
  a_read_avail: assert property ($fell(rd_n) |-> !$past(rx_avail_n))
    else $error("read without data");
  a_write_busy: assert property ($fell(wr) |-> ##[0:3] tx_space_n)
    else $error("space kept after write");
  a_suspend_pull: assert property (pull_low |-> power_enable_n)
    else $error("pull outside suspend");
  a_wake_input: assert property (rx_avail_ext_oe |-> !rx_avail_oe)
    else $error("status pin contention");
endmodule : upfp_chk
`default_nettype wire

// ==== tb/usb_parallel_fifo_port_test.sv ====
/* bench: both ends joined by the pin link; random traffic both ways, resets, wakeup
   assumes one-cycle request pulses taken while the controller is not busy */
`default_nettype none
module usb_parallel_fifo_port_test;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst_n, cf, su, we, pe, rv, rr, tv, tr, rs, rq_r, wq_r, wk, bz, dv, ts;
  logic [7:0] rd, td, wd, od, d;
  logic [7:0] rq[$], wq[$];
  int error_cnt, cmp_count, n;
  upfp_if link();
  upfp_device #(.WAKE_CYC(50)) u_upfp_device (.CLK(clk), .RST_N(rst_n), .PIN(link.device),
    .TEST(ts), .OSC_IN_PIN(1'b0), .OSC_OUT_PIN(), .USB_CONFIGURED(cf), .USB_SUSPEND(su),
    .CFG_REMOTE_WAKE(we), .CFG_SUSPEND_PULL(pe), .RX_VALID(rv), .RX_DATA(rd), .RX_READY(rr),
    .TX_VALID(tv), .TX_DATA(td), .TX_READY(tr), .RESUME_REQ(rs));
  upfp_ctrl #(.WAKE_CYC(50)) u_upfp_ctrl (.CLK(clk), .RST_N(rst_n), .PIN(link.ctrl),
    .RD_REQ(rq_r), .WR_REQ(wq_r), .WR_DATA(wd), .WAKE_REQ(wk), .BUSY(bz), .RD_VALID(dv),
    .RD_DATA(od), .WR_DONE(), .RESET_OUT_N(), .TEST_OUT(ts));
  upfp_chk u_upfp_chk (.CLK(clk), .RST_N(rst_n), .rd_n(link.rd_n), .wr(link.wr),
    .tx_space_n(link.tx_space_n), .tx_space_oe(link.tx_space_oe),
    .rx_avail_oe(link.rx_avail_oe), .rx_avail_ext_oe(link.rx_avail_ext_oe),
    .rx_avail_n(link.rx_avail_n), .power_enable_n(link.power_enable_n),
    .bus_dev_oe(link.bus_dev_oe), .pull_low(link.pull_low));
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  task automatic stop_test();
    if (error_cnt == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : stop_test
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    error_cnt++;
    stop_test();
  end
  // random stalls of the USB side; a handshake is checked with the ready
  // value that the next rising edge will see
  always @(negedge clk)
  begin
    tr = 1'($urandom_range(0, 1));
    if (dv === 1'b1)
      check(od, rq.pop_front());
    if (tv === 1'b1 && tr === 1'b1)
      check(td, wq.pop_front());
  end
  initial
  begin
    {rst_n, cf, su, we, pe, rv, rq_r, wq_r, wk, rd, wd} = '0;
    error_cnt = 0;
    cmp_count = 0;
    void'($urandom(32'hA279));
    repeat (16) @(negedge clk);
    cf = 1'b1;
    for (int p = 0; p < 2; p++)
    begin
      rst_n = 1'b1;
      for (int i = 0; i < 12; i++)
      begin
        d = 8'($urandom());
        while (bz !== 1'b0) @(negedge clk);
        if ($urandom_range(0, 1))
        begin
          wq.push_back(d);
          wd = d;
          wq_r = 1'b1;
        end
        else
        begin
          rq.push_back(d);
          rd = d;
          rv = 1'b1;
          while (rr !== 1'b1) @(negedge clk);
          @(negedge clk);
          rv = 1'b0;
          rq_r = 1'b1;
        end
        @(negedge clk);
        {rq_r, wq_r} = 2'b00;
        @(negedge clk);
      end
      repeat (40) @(negedge clk);
      check(8'(rq.size() + wq.size()), 8'h00);
      check({7'h00, link.power_enable_n}, 8'h00);
      rst_n = 1'b0;
      repeat (4) @(negedge clk);
    end
    rst_n = 1'b1;
    {su, we, pe} = 3'b111;
    repeat (8) @(negedge clk);
    check({7'h00, link.power_enable_n}, 8'h01);
    wk = 1'b1;
    @(negedge clk);
    wk = 1'b0;
    n = 0;
    while (rs !== 1'b1 && n < 300)
    begin
      @(negedge clk);
      n += int'(link.rx_avail_n === 1'b0);
    end
    check({7'h00, rs}, 8'h01);
    check({7'h00, n >= 50}, 8'h01);
    stop_test();
  end
endmodule : usb_parallel_fifo_port_test
`default_nettype wire
